// [verilog/page_status_pkg.sv]
package page_status_pkg;

    localparam int NUM_PORTS = 2;
    localparam int OFFSET_W = 7;
    localparam int ABS_W = 10;
    localparam int PAGE_W = 3;

    // in-page offset of the page control register, seen at serial 0x00 and 0x80
    localparam logic [OFFSET_W-1:0] PAGE_SELECT_OFS = 7'h00;
    localparam logic [ABS_W-1:0] LIVE_STATUS_MISC_ADDR = 10'h001;
    localparam logic [ABS_W-1:0] LIVE_STATUS_INPUTS_LOW_ADDR = 10'h002;
    localparam logic [ABS_W-1:0] LIVE_STATUS_INPUTS_HIGH_ADDR = 10'h003;

    localparam int AUTO_RETURN_BIT = 7;
    localparam int WRITE_MODE_BIT = 6;
    localparam int PAGE_LSB = 0;
    localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
    localparam logic [7:0] PAGE_SELECT_MASK = 8'hC7;
    localparam logic [PAGE_W-1:0] PAGE_HOME = 3'h0;
    localparam logic [PAGE_W-1:0] PAGE_FACTORY = 3'h3;

    localparam int MISC_COMP_BIT = 3;
    localparam int MISC_RAMP_BIT = 2;
    localparam int MISC_WAKE_BIT = 1;
    localparam int MISC_KEY_BIT = 0;

    // one register access as delivered by the serial interface engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic done;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic comparator_1v2_out;
        logic voltage_ramp_active;
        logic charger_wake_level;
        logic power_key_pressed;
        logic [15:0] general_input;
        logic [2:0] analog_mode;
        logic [2:0] analog_over_high;
    } live_in_t;

endpackage

// [verilog/page_select_port.sv]
module page_select_port
    import page_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire reg_req_t req,
    output logic [7:0] page_value,
    output logic hit_page_reg,
    output logic [ABS_W-1:0] abs_addr
);

    logic [7:0] page_select_reg;
    logic [7:0] page_select_next;

    assign page_value = page_select_reg;
    // bit 7 of the serial address only picks the half; offset 0 is always this register
    assign hit_page_reg = (req.addr[OFFSET_W-1:0] == PAGE_SELECT_OFS);
    assign abs_addr = {page_select_reg[PAGE_LSB +: PAGE_W], req.addr[OFFSET_W-1:0]};

    always_comb
    begin
        page_select_next = page_select_reg;
        if (req.wr && hit_page_reg)
        begin
            page_select_next = req.wdata & PAGE_SELECT_MASK;
        end
        // return happens after the write, so a page_auto_return set by this very transfer applies
        if (req.done && page_select_next[AUTO_RETURN_BIT])
        begin
            page_select_next[PAGE_LSB +: PAGE_W] = PAGE_HOME;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            page_select_reg <= PAGE_SELECT_RESET;
        end
        else
        begin
            page_select_reg <= page_select_next;
        end
    end

endmodule // page_select_port

// [verilog/page_control_and_live_status.sv]
// What this block does
// - page control register answers at offset zero of every page, 0x00 and 0x80.
// - each control port owns its own page control register.
// - page field 2:0 picks any page 0 to 7 of the register space.
// - with bit 7 set, page field returns to zero after the access.
// - bit 6 picks page write (0) or repeated write (1) for bursts.
// - status reads return levels sampled at the read, nothing latched.
// - status bits keep the polarity of their source signals.
// - misc status bit 3 is 1.2 V comparator, bit 1 charger wake level.
// - misc status bit 2 is high while any supply ramps voltage.
// - misc status bit 0 is high while the power key is pressed.
// - low inputs status shows inputs 7..0; analog pins show over-high flag.
module page_control_and_live_status
    import page_status_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire reg_req_t req [NUM_PORTS],
    input wire logic [7:0] ext_rdata [NUM_PORTS],
    input wire live_in_t live,
    output logic [7:0] rdata [NUM_PORTS],
    output logic rvalid [NUM_PORTS],
    output logic [ABS_W-1:0] ext_addr [NUM_PORTS],
    output logic ext_rd [NUM_PORTS],
    output logic ext_wr [NUM_PORTS],
    output logic repeated_write [NUM_PORTS],
    output logic [7:0] page_value [NUM_PORTS]
);

    logic [7:0] status_misc;
    logic [7:0] status_low;
    logic [7:0] status_high;

    // combinational on purpose: a latch here would return stale levels
    always_comb
    begin
        status_misc = 8'h00;
        status_misc[MISC_COMP_BIT] = live.comparator_1v2_out;
        status_misc[MISC_RAMP_BIT] = live.voltage_ramp_active;
        status_misc[MISC_WAKE_BIT] = live.charger_wake_level;
        status_misc[MISC_KEY_BIT] = live.power_key_pressed;
        status_low = live.general_input[7:0];
        for (int i = 0; i < 3; i++)
        begin
            if (live.analog_mode[i])
            begin
                status_low[i] = live.analog_over_high[i];
            end
        end
        status_high = live.general_input[15:8];
    end

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++)
        begin : g_port
            logic hit_page;
            logic [ABS_W-1:0] abs_addr;
            logic local_hit;
            logic [7:0] rdata_reg;
            logic [7:0] rdata_next;
            logic rvalid_reg;
            logic rvalid_next;

            page_select_port u_page (
                .clk(clk),
                .rst_n(rst_n),
                .req(req[p]),
                .page_value(page_value[p]),
                .hit_page_reg(hit_page),
                .abs_addr(abs_addr)
            );

            assign local_hit = hit_page || abs_addr == LIVE_STATUS_MISC_ADDR
                || abs_addr == LIVE_STATUS_INPUTS_LOW_ADDR
                || abs_addr == LIVE_STATUS_INPUTS_HIGH_ADDR;
            assign ext_addr[p] = abs_addr;
            assign ext_rd[p] = req[p].rd && !local_hit;
            // status registers are read only, writes to them are dropped
            assign ext_wr[p] = req[p].wr && !local_hit;
            assign repeated_write[p] = page_value[p][WRITE_MODE_BIT];
            assign rdata[p] = rdata_reg;
            assign rvalid[p] = rvalid_reg;

            always_comb
            begin
                rdata_next = rdata_reg;
                rvalid_next = req[p].rd;
                if (req[p].rd)
                begin
                    if (hit_page)
                    begin
                        rdata_next = page_value[p];
                    end
                    else if (abs_addr == LIVE_STATUS_MISC_ADDR)
                    begin
                        rdata_next = status_misc;
                    end
                    else if (abs_addr == LIVE_STATUS_INPUTS_LOW_ADDR)
                    begin
                        rdata_next = status_low;
                    end
                    else if (abs_addr == LIVE_STATUS_INPUTS_HIGH_ADDR)
                    begin
                        rdata_next = status_high;
                    end
                    else
                    begin
                        rdata_next = ext_rdata[p];
                    end
                end
            end

            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    rdata_reg <= 8'h00;
                    rvalid_reg <= 1'b0;
                end
                else
                begin
                    rdata_reg <= rdata_next;
                    rvalid_reg <= rvalid_next;
                end
            end
        end
    endgenerate

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // port 0 carries the status traffic in the bench, port 1 the page traffic
    page_reg_read_a: assert property (
        req[1].rd && req[1].addr[6:0] == 7'h00
        |=> rvalid[1] && rdata[1] == $past(page_value[1]))
        else $error("page control readback wrong");

    abs_route_a: assert property (
        ext_rd[1] |-> ext_addr[1] == {page_value[1][2:0], req[1].addr[6:0]})
        else $error("page routing wrong");

    auto_return_a: assert property (
        req[1].done && !req[1].wr && page_value[1][7] |=> page_value[1][2:0] == 3'h0)
        else $error("page did not return to zero");

    no_return_a: assert property (
        req[0].done && !req[0].wr && !page_value[0][7] |=> $stable(page_value[0]))
        else $error("page changed without auto return");

    write_mode_a: assert property (
        req[1].wr && req[1].addr[6:0] == 7'h00 && !req[1].done
        |=> repeated_write[1] == $past(req[1].wdata[6]))
        else $error("write mode not taken");

    misc_live_a: assert property (
        req[0].rd && req[0].addr[6:0] == 7'h01 && page_value[0][2:0] == 3'h0
        |=> rdata[0] == {4'h0, $past(live.comparator_1v2_out), $past(live.voltage_ramp_active),
            $past(live.charger_wake_level), $past(live.power_key_pressed)})
        else $error("misc status not live");

    low_live_a: assert property (
        req[0].rd && ext_addr[0] == 10'h002 |=> rdata[0][7:3] == $past(live.general_input[7:3])
        && rdata[0][2:0] == $past((live.analog_mode & live.analog_over_high)
            | (~live.analog_mode & live.general_input[2:0])))
        else $error("low input status wrong");

    high_live_a: assert property (
        req[0].rd && ext_addr[0] == 10'h003 |=> rdata[0] == $past(live.general_input[15:8]))
        else $error("high input status wrong");

    port_isolation_a: assert property (
        !req[0].wr && !req[0].done |=> $stable(page_value[0]))
        else $error("page changed by another port");

    reserved_zero_a: assert property (
        page_value[1][5:3] == 3'h0)
        else $error("reserved page bits stored");

    page_write_a: assert property (
        req[1].wr && req[1].addr[6:0] == 7'h00 && !req[1].done
        |=> page_value[1] == ($past(req[1].wdata) & 8'hC7))
        else $error("page write not stored");

    rvalid_pulse_a: assert property (
        1'b1 |=> rvalid[1] == $past(req[1].rd))
        else $error("read valid pulse wrong");

    status_wr_drop_a: assert property (
        req[0].wr && page_value[0][2:0] == 3'h0 && req[0].addr[6:0] >= 7'h01
        && req[0].addr[6:0] <= 7'h03 |-> !ext_wr[0])
        else $error("status write leaked out");

    far_write_a: assert property (
        req[1].wr && req[1].addr[6:0] > 7'h03
        |-> ext_wr[1] && ext_addr[1] == {page_value[1][2:0], req[1].addr[6:0]})
        else $error("far write not routed");

    far_read_a: assert property (
        req[1].rd && req[1].addr[6:0] > 7'h03 |-> ext_rd[1])
        else $error("far read not routed");

    ext_data_a: assert property (
        ext_rd[1] |=> rdata[1] == $past(ext_rdata[1]))
        else $error("far read data lost");

    home_stable_a: assert property (
        req[1].done && !req[1].wr && !page_value[1][7] |=> $stable(page_value[1]))
        else $error("page changed without auto return");

    peer_isolation_a: assert property (
        !req[1].wr && !req[1].done |=> $stable(page_value[1]))
        else $error("page changed by another port");

    page_auto_return_c: cover property (req[1].done && page_value[1][7] && page_value[1][2:0] != 3'h0);
    page1_c: cover property (ext_rd[1] && page_value[1][2:0] == 3'h1);
    status_c: cover property (req[0].rd && ext_addr[0] == 10'h001);
    repeat_c: cover property (repeated_write[1] && req[1].wr);
    analog_c: cover property (req[0].rd && ext_addr[0] == 10'h002 && live.analog_mode != 3'h0);

endmodule // page_control_and_live_status

// [dv/host_model.sv]
module host_model
    import page_status_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    output reg_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    // one byte per call; done follows a cycle later, as a serial stop would
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(negedge clk);
        req = '{rd: !w, wr: w, done: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req.rd = 1'b0;
        req.wr = 1'b0;
        req.done = 1'b1;
        q = rvalid ? rdata : 8'hXX;
        @(negedge clk);
        req.done = 1'b0;
    endtask
endmodule // host_model

// [dv/page_control_and_live_status_tb_top.sv]
module page_control_and_live_status_tb_top;
    import page_status_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t req [NUM_PORTS];
    logic [7:0] ext_rdata [NUM_PORTS];
    live_in_t live = '0;
    logic [7:0] rdata [NUM_PORTS];
    logic rvalid [NUM_PORTS];
    logic [ABS_W-1:0] ext_addr [NUM_PORTS];
    logic ext_rd [NUM_PORTS];
    logic ext_wr [NUM_PORTS];
    logic repeated_write [NUM_PORTS];
    logic [7:0] page_value [NUM_PORTS];
    logic [ABS_W-1:0] seen_addr = '0;
    logic [7:0] q;
    logic [7:0] e;
    logic [7:0] w;
    int far_writes = 0;
    int bad_count = 0;
    int n_checks = 0;

    always #5 clk = ~clk;
    assign ext_rdata[0] = 8'h5A;
    assign ext_rdata[1] = 8'hA5;
    always @(posedge clk) if (ext_rd[1]) seen_addr <= ext_addr[1];
    always @(posedge clk) if (ext_wr[0] || ext_wr[1]) far_writes <= far_writes + 1;

    page_control_and_live_status page_control_and_live_status_inst (
        .clk(clk), .rst_n(rst_n), .req(req), .ext_rdata(ext_rdata), .live(live),
        .rdata(rdata), .rvalid(rvalid), .ext_addr(ext_addr), .ext_rd(ext_rd),
        .ext_wr(ext_wr), .repeated_write(repeated_write), .page_value(page_value)
    );

    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : port
        host_model host_model_inst (
            .clk(clk), .rdata(rdata[p]), .rvalid(rvalid[p]), .req(req[p])
        );
    end

    task automatic check(input string name, input logic [ABS_W-1:0] seen,
        input logic [ABS_W-1:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #10000;
        bad_count++;
        print_verdict();
    end

    initial
    begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        check("page reset", page_value[0], PAGE_SELECT_RESET);
        // live levels change between passes, so a latched value would show
        for (int k = 0; k < 2; k++)
        begin
            live = k ? 26'h14A5C39 : 26'h2B5A3C6;
            e = {4'h0, live.comparator_1v2_out, live.voltage_ramp_active,
                live.charger_wake_level, live.power_key_pressed};
            port[0].host_model_inst.access(1'b0, 8'h01, 8'h00, q);
            check("misc status", q, e);
            w = q;
            port[0].host_model_inst.access(1'b1, 8'h01, w, q);
            port[0].host_model_inst.access(1'b0, 8'h01, 8'h00, q);
            check("misc after write back", q, e);
            for (int i = 0; i < 8; i++)
                e[i] = (i < 3 && live.analog_mode[i]) ? live.analog_over_high[i]
                    : live.general_input[i];
            port[0].host_model_inst.access(1'b0, 8'h02, 8'h00, q);
            check("inputs low", q, e);
            port[0].host_model_inst.access(1'b0, 8'h03, 8'h00, q);
            check("inputs high", q, live.general_input[15:8]);
        end
        check("status write dropped", 10'(far_writes), 10'h000);
        // reserved bits 5:3 are written high to see that they are dropped
        port[1].host_model_inst.access(1'b1, 8'h80, 8'h7A, q);
        check("page upper", page_value[1], 8'h42);
        check("other port", page_value[0], PAGE_SELECT_RESET);
        check("repeat mode", repeated_write[1], 1'b1);
        port[1].host_model_inst.access(1'b0, 8'h80, 8'h00, q);
        check("page read", q, 8'h42);
        port[1].host_model_inst.access(1'b1, 8'h00, 8'h00, q);
        check("page mode", repeated_write[1], 1'b0);
        // the factory page is never programmed by the host
        for (int p = 0; p < 3; p++)
        begin
            port[1].host_model_inst.access(1'b1, 8'h00, 8'(p), q);
            port[1].host_model_inst.access(1'b0, 8'h85, 8'h00, q);
            check("page route", seen_addr, {3'(p), 7'h05});
            check("far data", q, 8'hA5);
        end
        port[1].host_model_inst.access(1'b1, 8'h85, 8'h33, q);
        check("far write", 10'(far_writes), 10'h001);
        port[1].host_model_inst.access(1'b1, 8'h80, 8'h82, q);
        check("auto return", page_value[1], 8'h80);
        port[1].host_model_inst.access(1'b0, 8'h85, 8'h00, q);
        check("home route", seen_addr, 10'h005);
        print_verdict();
    end
endmodule // page_control_and_live_status_tb_top
